// File: logic/phx_pkg.sv
// Overview of operation
// - eight four-byte absolute difference sums, word results
// - find smallest of eight unsigned words, with lane
// - minimum and lane packed in low dword
// - zero flag when destination AND mask is zero
// - carry flag when destination AND inverted mask zero
// - per-lane qword equality on 128-bit operands
// - dword to word with unsigned saturation
// - per-lane signed qword greater-than compare
// - count one bits of low qword of source operand
// - 64-bit carry-less multiply using exclusive-or
// - convert four halves to singles, wide or not
// - convert eight or four singles to halves
package phx_pkg;
  localparam int VEC_W = 128;
  localparam int OP_W  = 4;
  localparam int HALF_LANES_FULL = 8;
  localparam int HALF_LANES_PART = 4;
  localparam int IDX_POS = 16;

  typedef enum logic [OP_W-1:0] {
    OP_BLOCK_ABS_DIFF_SUM,
    OP_HORIZONTAL_MIN_SEARCH,
    OP_PACKED_MASK_TEST,
    OP_QWORD_EQUAL_COMPARE,
    OP_DWORD_TO_WORD_PACK,
    OP_QWORD_GREATER_COMPARE,
    OP_SET_BIT_COUNT,
    OP_CARRYLESS_MULTIPLY,
    OP_HALF_TO_SINGLE_CONVERT,
    OP_SINGLE_TO_HALF_CONVERT
  } phx_op_t;

  typedef struct packed {
    logic             valid;
    phx_op_t          op;
    logic             wide;   // eight singles to halves when set, else four
    logic [VEC_W-1:0] src_a;  // destination operand
    logic [VEC_W-1:0] src_b;  // source operand
  } phx_req_t;

  typedef struct packed {
    logic             valid;
    logic [VEC_W-1:0] data;
    logic             zero_result_flag;
    logic             carry_result_flag;
  } phx_rsp_t;
endpackage : phx_pkg

// File: logic/phx_top.sv
`timescale 1ns/1ps
module phx_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // operands from issue
  input  wire phx_pkg::phx_req_t REQ,
  // result to writeback
  output phx_pkg::phx_rsp_t RSP
);
  import phx_pkg::*;

  typedef struct packed {
    phx_rsp_t rsp;
  } phx_state_t;

  phx_state_t state_reg;
  phx_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // half to single; denormal halves are normalised, not flushed
  function automatic logic [31:0] h2s(input logic [15:0] h);
    logic [4:0]  e;
    logic [9:0]  m;
    logic [7:0]  eo;
    logic [9:0]  mm;
    int          k;
    e = h[14:10];
    m = h[9:0];
    eo = 8'h00;
    mm = m;
    k = 0;
    if (e == 5'h1f) begin
      return {h[15], 8'hff, m, 13'h0000};
    end else if (e == 5'h00) begin
      if (m == 10'h000) begin
        return {h[15], 31'h00000000};
      end
      for (int i = 0; i < 10; i++) begin
        if (!mm[9]) begin
          mm = {mm[8:0], 1'b0};
          k++;
        end
      end
      mm = {mm[8:0], 1'b0};
      // leading one at bit 9-k weighs 2^(-15-k), so the biased exponent
      // is 127-15-k
      eo = 8'(112 - k);
      return {h[15], eo, mm, 13'h0000};
    end
    eo = 8'({3'h0, e} + 8'd112);
    return {h[15], eo, m, 13'h0000};
  endfunction : h2s

  // single to half, round to nearest even, overflow to infinity
  function automatic logic [15:0] s2h(input logic [31:0] f);
    logic [7:0]  e;
    logic [23:0] m;
    logic [24:0] sh;
    logic [10:0] r;
    logic        g;
    logic        st;
    int          ex;
    int          d;
    e = f[30:23];
    m = {1'b1, f[22:0]};
    ex = int'(e) - 112;
    if (e == 8'hff) begin
      return {f[31], 5'h1f, (f[22:0] != 23'h0) ? 10'h200 : 10'h000};
    end
    if (ex >= 31) begin
      return {f[31], 5'h1f, 10'h000};
    end
    if (ex <= 0) begin
      d = 1 - ex;
      if (d > 24 || e == 8'h00) begin
        return {f[31], 15'h0000};
      end
      sh = {m, 1'b0} >> d;
      st = (({m, 1'b0} & ((25'h1 << d) - 25'h1)) != 25'h0);
      r = {1'b0, sh[23:14]};
      g = sh[13];
      st = st | (sh[12:0] != 13'h0);
      if (g && (st || r[0])) begin
        r = r + 11'h001;
      end
      return {f[31], r[10] ? 5'h01 : 5'h00, r[9:0]};
    end
    r = {1'b0, m[22:13]};
    g = m[12];
    st = (m[11:0] != 12'h000);
    if (g && (st || r[0])) begin
      r = r + 11'h001;
    end
    if (r[10]) begin
      ex = ex + 1;
      r = 11'h000;
    end
    if (ex >= 31) begin
      return {f[31], 5'h1f, 10'h000};
    end
    return {f[31], 5'(ex), r[9:0]};
  endfunction : s2h

  ////////////////////////////////////////////////////////////////////////
  // combinational datapath, result registered one cycle later
  always_comb begin
    logic [15:0]  acc;
    logic [7:0]   da;
    logic [15:0]  minv;
    logic [2:0]   mini;
    logic [31:0]  dw;
    logic [127:0] clm;
    logic [7:0]   cnt;
    int           n;
    acc = 16'h0000;
    da = 8'h00;
    minv = 16'hffff;
    mini = 3'h0;
    dw = 32'h00000000;
    clm = 128'h0;
    cnt = 8'h00;
    n = HALF_LANES_FULL;
    state_next = state_reg;
    state_next.rsp.valid = REQ.valid;
    if (REQ.valid) begin
      state_next.rsp.data = '0;
      state_next.rsp.zero_result_flag = 1'b0;
      state_next.rsp.carry_result_flag = 1'b0;
      case (REQ.op)
        OP_BLOCK_ABS_DIFF_SUM: begin
          // sliding 4-byte window over src_a, fixed block from src_b
          for (int j = 0; j < 8; j++) begin
            acc = 16'h0000;
            for (int b = 0; b < 4; b++) begin
              da = (REQ.src_a[(j+b)*8 +: 8] > REQ.src_b[b*8 +: 8]) ?
                   REQ.src_a[(j+b)*8 +: 8] - REQ.src_b[b*8 +: 8] :
                   REQ.src_b[b*8 +: 8] - REQ.src_a[(j+b)*8 +: 8];
              acc = acc + {8'h00, da};
            end
            state_next.rsp.data[j*16 +: 16] = acc;
          end
        end
        OP_HORIZONTAL_MIN_SEARCH: begin
          minv = REQ.src_b[15:0];
          for (int j = 1; j < 8; j++) begin
            // strict less keeps the lowest lane on ties
            if (REQ.src_b[j*16 +: 16] < minv) begin
              minv = REQ.src_b[j*16 +: 16];
              mini = 3'(j);
            end
          end
          state_next.rsp.data[15:0] = minv;
          state_next.rsp.data[IDX_POS +: 3] = mini;
        end
        OP_PACKED_MASK_TEST: begin
          state_next.rsp.zero_result_flag =
            ((REQ.src_a & REQ.src_b) == '0);
          state_next.rsp.carry_result_flag =
            ((REQ.src_a & ~REQ.src_b) == '0);
        end
        OP_QWORD_EQUAL_COMPARE: begin
          for (int j = 0; j < 2; j++) begin
            state_next.rsp.data[j*64 +: 64] =
              {64{REQ.src_a[j*64 +: 64] == REQ.src_b[j*64 +: 64]}};
          end
        end
        OP_DWORD_TO_WORD_PACK: begin
          // signed dwords: negative clamps to 0, large to ffff
          for (int j = 0; j < 8; j++) begin
            // modulo keeps both selects in range on every unrolled lane
            dw = (j < 4) ? REQ.src_a[(j%4)*32 +: 32] :
                           REQ.src_b[(j%4)*32 +: 32];
            state_next.rsp.data[j*16 +: 16] = dw[31] ? 16'h0000 :
              (dw[30:16] != 15'h0) ? 16'hffff : dw[15:0];
          end
        end
        OP_QWORD_GREATER_COMPARE: begin
          for (int j = 0; j < 2; j++) begin
            state_next.rsp.data[j*64 +: 64] =
              {64{$signed(REQ.src_a[j*64 +: 64]) >
                  $signed(REQ.src_b[j*64 +: 64])}};
          end
        end
        OP_SET_BIT_COUNT: begin
          for (int j = 0; j < 64; j++) begin
            cnt = cnt + {7'h00, REQ.src_b[j]};
          end
          state_next.rsp.data[7:0] = cnt;
          state_next.rsp.zero_result_flag = (REQ.src_b[63:0] == 64'h0);
        end
        OP_CARRYLESS_MULTIPLY: begin
          // low qwords multiplied; the full product needs 127 bits
          for (int j = 0; j < 64; j++) begin
            if (REQ.src_b[j]) begin
              clm = clm ^ ({64'h0, REQ.src_a[63:0]} << j);
            end
          end
          state_next.rsp.data = clm;
        end
        OP_HALF_TO_SINGLE_CONVERT: begin
          n = REQ.wide ? HALF_LANES_FULL : HALF_LANES_PART;
          // four lanes only fit the 128-bit result; wide keeps low four
          for (int j = 0; j < 4; j++) begin
            if (j < n) begin
              state_next.rsp.data[j*32 +: 32] =
                h2s(REQ.src_b[j*16 +: 16]);
            end
          end
        end
        OP_SINGLE_TO_HALF_CONVERT: begin
          n = REQ.wide ? HALF_LANES_FULL : HALF_LANES_PART;
          for (int j = 0; j < 8; j++) begin
            if (j < n) begin
              dw = (j < 4) ? REQ.src_b[(j%4)*32 +: 32] :
                             REQ.src_a[(j%4)*32 +: 32];
              state_next.rsp.data[j*16 +: 16] = s2h(dw);
            end
          end
        end
        default: begin
          state_next.rsp.data = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign RSP = state_reg.rsp;
endmodule : phx_top

// File: verification/phx_props.sv
`timescale 1ns/1ps
module phx_props
  import phx_pkg::*;
(
  // clock and reset
  input wire logic              MCLK,
  input wire logic              NRST,
  // watched ports
  input wire phx_pkg::phx_req_t REQ,
  input wire phx_pkg::phx_rsp_t RSP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  //////////////////////////////////////////////////////////////////////////
  // one request of a given kind taken at this edge
  sequence s_op(phx_op_t o);
    REQ.valid && REQ.op == o;
  endsequence
  property p_sad;
    s_op(OP_BLOCK_ABS_DIFF_SUM) |=> RSP.valid && RSP.data[15:10] == 6'h0;
  endproperty
  a_sad: assert property (p_sad) else $error("sum too wide");
  property p_min;
    s_op(OP_HORIZONTAL_MIN_SEARCH) |=> RSP.data[127:19] == 109'h0;
  endproperty
  a_min: assert property (p_min) else $error("min upper bits");
  property p_zf;
    s_op(OP_PACKED_MASK_TEST) |=> RSP.zero_result_flag ==
      (($past(REQ.src_a) & $past(REQ.src_b)) == 128'h0);
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag");
  property p_cf;
    s_op(OP_PACKED_MASK_TEST) |=> RSP.carry_result_flag ==
      (($past(REQ.src_a) & ~$past(REQ.src_b)) == 128'h0);
  endproperty
  a_cf: assert property (p_cf) else $error("carry flag");
  property p_eq;
    s_op(OP_QWORD_EQUAL_COMPARE) |=> RSP.data[0] ==
      ($past(REQ.src_a[63:0]) == $past(REQ.src_b[63:0]));
  endproperty
  a_eq: assert property (p_eq) else $error("equal lane");
  property p_gt;
    s_op(OP_QWORD_GREATER_COMPARE) |=> RSP.data[64] ==
      ($signed($past(REQ.src_a[127:64])) > $signed($past(REQ.src_b[127:64])));
  endproperty
  a_gt: assert property (p_gt) else $error("greater lane");
  property p_cnt;
    s_op(OP_SET_BIT_COUNT) |=>
      RSP.data[7:0] == 8'($countones($past(REQ.src_b[63:0])));
  endproperty
  a_cnt: assert property (p_cnt) else $error("bit count");
  property p_clm;
    s_op(OP_CARRYLESS_MULTIPLY) |=>
      RSP.data[0] == ($past(REQ.src_a[0]) & $past(REQ.src_b[0]));
  endproperty
  a_clm: assert property (p_clm) else $error("clmul bit 0");
endmodule : phx_props

// File: verification/phx_issue_model.sv
`timescale 1ns/1ps
module phx_issue_model (
  // clock
  input wire logic              MCLK,
  // result from the block
  input wire phx_pkg::phx_rsp_t RSP,
  // request toward the block
  output phx_pkg::phx_req_t     REQ
);
  import phx_pkg::*;
  initial REQ = '0;
  // operands stand for the taking edge only, then show inverted junk
  // so a design that samples late cannot pass by luck
  task automatic issue(input phx_op_t o, input logic w,
                       input logic [VEC_W-1:0] a, b, output phx_rsp_t r);
    phx_req_t q;
    q = '{1'b1, o, w, a, b};
    @(posedge MCLK) REQ <= q;
    @(posedge MCLK) REQ <= phx_req_t'({1'b0, ~q[$bits(q)-2:0]});
    #1 r = RSP;
  endtask : issue
endmodule : phx_issue_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import phx_pkg::*;
  logic     MCLK = 1'b0;
  logic     NRST = 1'b0;
  phx_req_t REQ;
  phx_rsp_t RSP;
  phx_rsp_t r;
  int       failures = 0;
  int       compares = 0;
  //////////////////////////////////////////////////////////////////////////
  // core clock, 4 ns period
  always #2 MCLK = ~MCLK;
  phx_top phx_top_i (.MCLK(MCLK), .NRST(NRST), .REQ(REQ), .RSP(RSP));
  phx_issue_model phx_issue_model_i (.MCLK(MCLK), .RSP(RSP), .REQ(REQ));
  // four-state compare so an unknown never matches
  task automatic chk(input string n, input logic [128:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cd(input string n, input logic [127:0] e);
    chk(n, {r.valid, r.data}, {1'b1, e});
  endtask : cd
  task automatic go(input phx_op_t o, input logic w, input logic [127:0] a,
                    input logic [127:0] b);
    phx_issue_model_i.issue(o, w, a, b, r);
  endtask : go
  //////////////////////////////////////////////////////////////////////////
  // windows slide one byte per result word
  task automatic t_sad();
    logic [127:0] a, e;
    logic [31:0]  b;
    int           d;
    b = 32'h00ff_1080;
    e = '0;
    for (int k = 0; k < 16; k++) a[k*8 +: 8] = 8'(k * 37);
    for (int j = 0; j < 8; j++)
      for (int k = 0; k < 4; k++) begin
        d = int'(a[(j+k)*8 +: 8]) - int'(b[k*8 +: 8]);
        e[j*16 +: 16] += 16'(d < 0 ? -d : d);
      end
    go(OP_BLOCK_ABS_DIFF_SUM, 1'b0, a, {96'h0, b});
    cd("sad", e);
    $display("test sad done");
  endtask : t_sad
  // minimum 3 sits in lanes 2 and 5; the lower lane must win
  task automatic t_min();
    go(OP_HORIZONTAL_MIN_SEARCH, 1'b0, '1,
       128'hffff_0005_0003_0008_ffff_0003_0007_0009);
    cd("min", 128'h2_0003);
    $display("test min done");
  endtask : t_min
  task automatic t_mask();
    go(OP_PACKED_MASK_TEST, 1'b0, {1'b1, 127'hf0}, 128'h0f);
    chk("zf", r.zero_result_flag, 1'b1);
    chk("cf", r.carry_result_flag, 1'b0);
    go(OP_PACKED_MASK_TEST, 1'b0, {1'b1, 127'h0f}, {1'b1, 127'hff});
    chk("zf", r.zero_result_flag, 1'b0);
    chk("cf", r.carry_result_flag, 1'b1);
    // zero destination sets both flags; data stays clear
    go(OP_PACKED_MASK_TEST, 1'b0, '0, '1);
    cd("mask data", 128'h0);
    chk("zf", r.zero_result_flag, 1'b1);
    chk("cf", r.carry_result_flag, 1'b1);
    $display("test mask done");
  endtask : t_mask
  // minus one against one tells a signed compare from an unsigned one
  task automatic t_cmp();
    logic [127:0] a, b;
    a = {64'h5, {64{1'b1}}};
    b = {64'h5, 64'h1};
    go(OP_QWORD_EQUAL_COMPARE, 1'b0, a, b);
    cd("eq", {{64{1'b1}}, 64'h0});
    go(OP_QWORD_GREATER_COMPARE, 1'b0, a, b);
    cd("gt", 128'h0);
    go(OP_QWORD_GREATER_COMPARE, 1'b0, b, a);
    cd("gt", {64'h0, {64{1'b1}}});
    $display("test cmp done");
  endtask : t_cmp
  // negative, over-range and in-range dwords at each clamp edge
  task automatic t_misc();
    go(OP_DWORD_TO_WORD_PACK, 1'b0,
       128'h0000_ffff_0000_1234_0001_0000_ffff_fffb,
       128'h0000_0001_0000_0000_7fff_ffff_8000_0000);
    cd("pack", 128'h0001_0000_ffff_0000_ffff_1234_ffff_0000);
    go(OP_SET_BIT_COUNT, 1'b0, '0, {64'hffff, 64'h8000_0000_0000_0003});
    cd("count", 128'h3);
    go(OP_CARRYLESS_MULTIPLY, 1'b0, {64'hff, 64'h8000_0000_0000_0003},
       {64'hf0, 64'h8000_0000_0000_0003});
    cd("clmul", {64'h4000_0000_0000_0000, 64'h5});
    $display("test misc done");
  endtask : t_misc
  // one, minus two, zero, infinity, overflow and a quiet nan
  task automatic t_cvt();
    for (int w = 0; w < 2; w++) begin
      go(OP_HALF_TO_SINGLE_CONVERT, 1'(w), '0,
         {64'h1234, 64'h7c00_0000_c000_3c00});
      cd("h2s", 128'h7f80_0000_0000_0000_c000_0000_3f80_0000);
    end
    // subnormal halves, smallest and largest, and a nan, both ways
    go(OP_HALF_TO_SINGLE_CONVERT, 1'b0, '0,
       {64'h0, 64'h7e00_83ff_0200_0001});
    cd("h2s sub", 128'h7fc0_0000_b87f_c000_3800_0000_3380_0000);
    go(OP_SINGLE_TO_HALF_CONVERT, 1'b0, '1,
       128'h7fc0_0000_b87f_c000_3800_0000_3380_0000);
    cd("s2h sub", 128'h7e00_83ff_0200_0001);
    go(OP_SINGLE_TO_HALF_CONVERT, 1'b1,
       128'h7fc0_0000_4780_0000_3f00_0000_4000_0000,
       128'h7f80_0000_0000_0000_c000_0000_3f80_0000);
    cd("s2h", 128'h7e00_7c00_3800_4000_7c00_0000_c000_3c00);
    go(OP_SINGLE_TO_HALF_CONVERT, 1'b0, '1,
       128'h7f80_0000_0000_0000_c000_0000_3f80_0000);
    cd("s2h", 128'h7c00_0000_c000_3c00);
    $display("test cvt done");
  endtask : t_cvt
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge MCLK);
    NRST <= 1'b1;
    t_sad();
    t_min();
    t_mask();
    t_cmp();
    t_misc();
    t_cvt();
    print_verdict();
  end
  // about 40 cycles of traffic; ten times that means a hang
  initial begin
    repeat (400) @(posedge MCLK);
    failures++;
    print_verdict();
  end
endmodule : testbench
bind phx_top phx_props phx_props_i (.MCLK(MCLK), .NRST(NRST), .REQ(REQ),
                                    .RSP(RSP));
